// ---- rtl/lag_filter.sv ----
`timescale 1ns/1ps
module lag_filter #(
	parameter int W = 16
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire logic                tick,
	input  wire logic                clear,
	input  wire logic [3:0]          shift,
	input  wire logic signed [W-1:0] din,
	output logic signed [W-1:0]      dout
);
	logic signed [W:0] diff;
	logic signed [W:0] step;
	logic signed [W:0] sum;

	always_comb begin
		diff = {din[W-1], din} - {dout[W-1], dout};
		step = diff >>> shift;
		sum = {dout[W-1], dout} + step;
	end

	// First-order lag: larger shift gives longer time constant
	always_ff @(posedge clk_sys) begin
		if (rst || (ce && clear)) begin
			dout <= '0;
		end else if (ce && tick) begin
			dout <= sum[W-1:0]; // see RULE_11
		end
	end
endmodule

// ---- rtl/observer_gate.sv ----
`timescale 1ns/1ps
module observer_gate
	import servo_obs_pkg::*;
(
	observer_gate_if.gate g
);
	logic base_ok;

	always_comb begin
		base_ok = (g.mode_sel == MODE_POSITION || g.mode_sel == MODE_VELOCITY) // see RULE_01
			&& g.servo_on // see RULE_02
			&& (g.auto_tune == AUTO_TUNE_OFF); // see RULE_03
		g.speed_active = base_ok && g.func_word[FX_SPEED_OBS_BIT]; // see RULE_04
		g.dist_active = base_ok
			&& !g.func_word[FX_SPEED_OBS_BIT] // see RULE_07
			&& g.gain_sw_en // see RULE_08
			&& g.func_word[FX_DIST_OBS_BIT] // see RULE_09
			&& (!g.func_word[FX_DIST_SCOPE_BIT] || g.first_gain); // see RULE_09
	end
endmodule

// ---- rtl/observer_gate_if.sv ----
`timescale 1ns/1ps
interface observer_gate_if;
	logic [3:0]  mode_sel;
	logic [3:0]  auto_tune;
	logic [15:0] func_word;
	logic        servo_on;
	logic        gain_sw_en;
	logic        first_gain;
	logic        speed_active;
	logic        dist_active;

	modport gate (
		input  mode_sel,
		input  auto_tune,
		input  func_word,
		input  servo_on,
		input  gain_sw_en,
		input  first_gain,
		output speed_active,
		output dist_active
	);
	modport core (
		output mode_sel,
		output auto_tune,
		output func_word,
		output servo_on,
		output gain_sw_en,
		output first_gain,
		input  speed_active,
		input  dist_active
	);
endinterface

// ---- rtl/servo_obs_pkg.sv ----
package servo_obs_pkg;
	// Register byte offsets
	localparam logic [7:0] FUNC_EXP_OFS     = 8'h00;
	localparam logic [7:0] MODE_CFG_OFS     = 8'h04;
	localparam logic [7:0] INERTIA_OFS      = 8'h08;
	localparam logic [7:0] DIST_GAIN_OFS    = 8'h0C;
	localparam logic [7:0] DIST_FILT_OFS    = 8'h10;
	localparam logic [7:0] STATUS_OFS       = 8'h14;
	// Function expansion word fields
	localparam int FX_SPEED_OBS_BIT         = 0;
	localparam int FX_DIST_OBS_BIT          = 1;
	localparam int FX_DIST_SCOPE_BIT        = 2;
	// Mode configuration fields
	localparam int MODE_SEL_LSB             = 0;
	localparam int AUTO_TUNE_LSB            = 8;
	localparam int GAIN_SW_EN_BIT           = 16;
	// Status fields
	localparam int ST_SPEED_ACT_BIT         = 0;
	localparam int ST_DIST_ACT_BIT          = 1;
	localparam int ST_DIST_EST_LSB          = 16;
	// Control mode and auto-tuning codes
	localparam logic [3:0] MODE_POSITION    = 4'h0;
	localparam logic [3:0] MODE_VELOCITY    = 4'h1;
	localparam logic [3:0] AUTO_TUNE_OFF    = 4'h0;
	// Reset values
	localparam logic [15:0] FUNC_EXP_RST    = 16'h0000;
	localparam logic [3:0] MODE_SEL_RST     = 4'h0;
	localparam logic GAIN_SW_RST            = 1'b0;
	localparam logic [3:0] AUTO_TUNE_RST    = 4'h1;
	localparam logic [15:0] INERTIA_RST     = 16'h0064;
	localparam logic [15:0] DIST_GAIN_RST   = 16'h0000;
	localparam logic [3:0] DIST_FILT_RST    = 4'h8;
	// Load model and compensation scaling
	localparam logic [17:0] INERTIA_BASE    = 18'h00064;
	localparam int ACC_SHIFT                = 8;
	localparam int OBS_CORR_SHIFT           = 3;
	localparam int COMP_SHIFT               = 8;
endpackage

// ---- rtl/servo_speed_disturbance_observer.sv ----
`timescale 1ns/1ps
// Overview of operation
// RULE_01 - Observers act only in position (0) or velocity (1) control mode.
// RULE_02 - Both observers stay inactive unless the drive is servo-on.
// RULE_03 - Both observers need real-time auto-tuning setting zero.
// RULE_04 - Function word bit 0 enables the instantaneous speed observer.
// RULE_05 - Active speed observer replaces measured speed with load-model estimate.
// RULE_06 - Load model uses the inertia ratio setting as load inertia.
// RULE_07 - Disturbance observer acts only while speed observer bit is zero.
// RULE_08 - Disturbance observer also needs gain switchover enabled.
// RULE_09 - Bit 1 enables disturbance observer; bit 2 limits it to first gain.
// RULE_10 - Compensation is estimated disturbance scaled by compensating gain.
// RULE_11 - Disturbance estimate is filtered with the configured time constant.
// RULE_12 - Inactive observer is bypassed: measured speed, zero compensation.
module servo_speed_disturbance_observer
	import servo_obs_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic                clk_sys,
	input  wire logic                rst,
	input  wire logic                ce,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                ctrl_tick,
	input  wire logic                servo_on,
	input  wire logic                first_gain,
	input  wire logic signed [W-1:0] meas_speed,
	input  wire logic signed [W-1:0] torque_cmd,
	output logic signed [W-1:0]      speed_fb,
	output logic signed [W-1:0]      torque_comp,
	output logic                     speed_obs_active,
	output logic                     dist_obs_active
);
	function automatic logic signed [W-1:0] sat_w(input logic signed [39:0] v);
		logic signed [39:0] hi;
		logic signed [39:0] lo;
		hi = (40'sh1 <<< (W - 1)) - 40'sh1;
		lo = -(40'sh1 <<< (W - 1));
		if (v > hi) begin
			sat_w = hi[W-1:0];
		end else if (v < lo) begin
			sat_w = lo[W-1:0];
		end else begin
			sat_w = v[W-1:0];
		end
	endfunction

	function automatic logic signed [39:0] ext40(input logic signed [W-1:0] v);
		ext40 = {{(40-W){v[W-1]}}, v};
	endfunction

	logic [15:0]            func_word_reg;
	logic [3:0]             mode_sel_reg;
	logic [3:0]             auto_tune_reg;
	logic                   gain_sw_en_reg;
	logic [15:0]            inertia_reg;
	logic [15:0]            dist_gain_reg;
	logic [3:0]             dist_filt_reg;
	logic [31:0]            rdata_reg;
	logic                   err_reg;
	logic signed [W-1:0]    est_speed_reg;
	logic signed [W-1:0]    est_speed_next;
	logic signed [W-1:0]    meas_prev_reg;
	logic signed [W-1:0]    speed_fb_reg;
	logic signed [W-1:0]    torque_comp_reg;
	logic signed [W-1:0]    torque_comp_next;
	logic signed [W-1:0]    dist_raw;
	logic signed [W-1:0]    dist_filt;
	logic [17:0]            j_total;
	logic signed [39:0]     acc_num;
	logic signed [39:0]     acc_term;
	logic signed [39:0]     corr_term;
	logic signed [39:0]     dmeas;
	logic signed [39:0]     dyn_torque;
	logic signed [39:0]     comp_prod;
	logic                   addr_hit;
	logic                   wr_en;
	logic                   step;
	logic signed [39:0]     j_div;
	logic signed [39:0]     div_rem;

	observer_gate_if gi ();

	assign gi.mode_sel = mode_sel_reg;
	assign gi.auto_tune = auto_tune_reg;
	assign gi.func_word = func_word_reg;
	assign gi.servo_on = servo_on;
	assign gi.gain_sw_en = gain_sw_en_reg;
	assign gi.first_gain = first_gain;

	observer_gate u_gate (
		.g (gi.gate)
	);

	// APB slave: zero wait states while enabled, frozen with ce
	always_comb begin
		case (paddr)
			FUNC_EXP_OFS, MODE_CFG_OFS, INERTIA_OFS,
			DIST_GAIN_OFS, DIST_FILT_OFS, STATUS_OFS: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	assign pready = ce;
	assign pslverr = psel && penable && ce && err_reg;
	assign prdata = rdata_reg;
	assign wr_en = psel && penable && ce && pwrite && !err_reg;
	assign step = ce && ctrl_tick;

	// Decode captured in the setup cycle so read data comes from a flop
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_reg <= 32'h00000000;
			err_reg <= 1'b0;
		end else if (ce && psel && !penable) begin
			err_reg <= !addr_hit;
			rdata_reg <= 32'h00000000;
			if (!pwrite) begin
				case (paddr)
					FUNC_EXP_OFS: rdata_reg <= {16'h0000, func_word_reg};
					MODE_CFG_OFS: begin
						rdata_reg[MODE_SEL_LSB +: 4] <= mode_sel_reg;
						rdata_reg[AUTO_TUNE_LSB +: 4] <= auto_tune_reg;
						rdata_reg[GAIN_SW_EN_BIT] <= gain_sw_en_reg;
					end
					INERTIA_OFS: rdata_reg <= {16'h0000, inertia_reg};
					DIST_GAIN_OFS: rdata_reg <= {16'h0000, dist_gain_reg};
					DIST_FILT_OFS: rdata_reg <= {28'h0000000, dist_filt_reg};
					STATUS_OFS: begin
						rdata_reg[ST_SPEED_ACT_BIT] <= gi.speed_active;
						rdata_reg[ST_DIST_ACT_BIT] <= gi.dist_active;
						rdata_reg[ST_DIST_EST_LSB +: 16] <= 16'(dist_filt);
					end
					default: rdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			func_word_reg <= FUNC_EXP_RST;
			mode_sel_reg <= MODE_SEL_RST;
			auto_tune_reg <= AUTO_TUNE_RST;
			gain_sw_en_reg <= GAIN_SW_RST;
			inertia_reg <= INERTIA_RST;
			dist_gain_reg <= DIST_GAIN_RST;
			dist_filt_reg <= DIST_FILT_RST;
		end else if (wr_en) begin
			case (paddr)
				FUNC_EXP_OFS: func_word_reg <= pwdata[15:0];
				MODE_CFG_OFS: begin
					mode_sel_reg <= pwdata[MODE_SEL_LSB +: 4];
					auto_tune_reg <= pwdata[AUTO_TUNE_LSB +: 4];
					gain_sw_en_reg <= pwdata[GAIN_SW_EN_BIT];
				end
				INERTIA_OFS: inertia_reg <= pwdata[15:0];
				DIST_GAIN_OFS: dist_gain_reg <= pwdata[15:0];
				DIST_FILT_OFS: dist_filt_reg <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	// Load model: total inertia in percent of motor inertia
	always_comb begin
		j_total = INERTIA_BASE + {2'b00, inertia_reg}; // see RULE_06
		acc_num = ext40(torque_cmd) <<< ACC_SHIFT;
		acc_term = acc_num / $signed({22'h000000, j_total}); // see RULE_06
		corr_term = (ext40(meas_speed) - ext40(est_speed_reg)) >>> OBS_CORR_SHIFT;
		est_speed_next = sat_w(ext40(est_speed_reg) + acc_term + corr_term);
	end

	// Divider check: quotient stays within one step of the true ratio
	always_comb begin
		j_div = $signed({22'h000000, j_total});
		div_rem = acc_num - acc_term * j_div;
	end

	// Estimator tracks measured speed while idle to avoid a bump on enable
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			est_speed_reg <= '0;
		end else if (step) begin
			if (gi.speed_active) begin
				est_speed_reg <= est_speed_next;
			end else begin
				est_speed_reg <= meas_speed; // see RULE_12
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			speed_fb_reg <= '0;
		end else if (step) begin
			speed_fb_reg <= gi.speed_active ? est_speed_next : meas_speed; // see RULE_05
		end
	end

	// Disturbance: commanded torque minus torque explained by acceleration
	always_comb begin
		dmeas = ext40(meas_speed) - ext40(meas_prev_reg);
		dyn_torque = ($signed({22'h000000, j_total}) * dmeas) >>> ACC_SHIFT;
		dist_raw = sat_w(ext40(torque_cmd) - dyn_torque);
		comp_prod = (ext40(dist_filt) * $signed({24'h000000, dist_gain_reg})) >>> COMP_SHIFT;
		torque_comp_next = sat_w(-comp_prod); // see RULE_10
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meas_prev_reg <= '0;
		end else if (step) begin
			meas_prev_reg <= meas_speed;
		end
	end

	lag_filter #(
		.W (W)
	) u_dist_filter (
		.clk_sys (clk_sys),
		.rst     (rst),
		.ce      (ce),
		.tick    (ctrl_tick),
		.clear   (!gi.dist_active),
		.shift   (dist_filt_reg),
		.din     (dist_raw),
		.dout    (dist_filt)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			torque_comp_reg <= '0;
		end else if (step) begin
			torque_comp_reg <= gi.dist_active ? torque_comp_next : '0; // see RULE_12
		end
	end

	assign speed_fb = speed_fb_reg;
	assign torque_comp = torque_comp_reg;
	assign speed_obs_active = gi.speed_active;
	assign dist_obs_active = gi.dist_active;

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_write_func;
		psel && penable && pwrite && pready && (paddr == FUNC_EXP_OFS);
	endsequence

	a_mode_gate: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_01
		(gi.speed_active || gi.dist_active) |-> (mode_sel_reg <= MODE_VELOCITY))
		else $error("observer active outside position or velocity mode");

	a_servo_gate: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_02
		!servo_on |-> !(speed_obs_active || dist_obs_active))
		else $error("observer active while servo off");

	a_tuning_gate: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_03
		(auto_tune_reg != AUTO_TUNE_OFF) |-> !gi.speed_active && !gi.dist_active)
		else $error("observer active with auto-tuning enabled");

	a_speed_enable: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_04
		(servo_on && auto_tune_reg == AUTO_TUNE_OFF && mode_sel_reg <= MODE_VELOCITY)
		|-> (gi.speed_active == func_word_reg[FX_SPEED_OBS_BIT]))
		else $error("speed observer enable bit not followed");

	a_speed_path: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_05
		(step && gi.speed_active) |=> (speed_fb == $past(est_speed_next)))
		else $error("speed feedback not taken from estimate");

	a_dist_exclusive: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_07
		func_word_reg[FX_SPEED_OBS_BIT] |-> !dist_obs_active)
		else $error("disturbance observer active with speed observer enabled");

	a_gain_switch: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_08
		!gain_sw_en_reg |-> !dist_obs_active)
		else $error("disturbance observer active without gain switchover");

	a_dist_scope: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_09
		(func_word_reg[FX_DIST_SCOPE_BIT] && !first_gain) || !func_word_reg[FX_DIST_OBS_BIT]
		|-> !dist_obs_active)
		else $error("disturbance observer scope not respected");

	a_bypass_path: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_12
		(step && !gi.speed_active && !gi.dist_active)
		|=> (speed_fb == $past(meas_speed)) && (torque_comp == '0))
		else $error("inactive observer not bypassed");

	a_func_write: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_04
		s_setup ##1 s_write_func |=> (func_word_reg == $past(pwdata[15:0])))
		else $error("function word write lost");

	sequence s_dist_step;
		step && gi.dist_active;
	endsequence

	a_load_divide: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_06
		(div_rem < j_div) && (-div_rem < j_div))
		else $error("load model quotient does not follow the inertia divisor");

	a_comp_unity: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_10
		s_dist_step ##0 (dist_gain_reg == 16'(1 << COMP_SHIFT))
			##0 (dist_filt != {1'b1, {(W-1){1'b0}}})
		|=> (torque_comp == -$past(dist_filt)))
		else $error("unity compensating gain does not mirror the estimate");

	a_comp_zero: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_10
		(step && dist_gain_reg == '0) |=> (torque_comp == '0))
		else $error("compensation present with zero compensating gain");

	a_filter_pass: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_11
		s_dist_step ##0 (dist_filt_reg == '0) |=> (dist_filt == $past(dist_raw)))
		else $error("zero filter setting delayed the disturbance estimate");

	a_filter_rise: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_11
		s_dist_step ##0 (dist_raw >= dist_filt)
		|=> (dist_filt >= $past(dist_filt)) && (dist_filt <= $past(dist_raw)))
		else $error("rising filtered estimate left the span to its input");

	a_filter_fall: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_11
		s_dist_step ##0 (dist_raw < dist_filt)
		|=> (dist_filt <= $past(dist_filt)) && (dist_filt >= $past(dist_raw)))
		else $error("falling filtered estimate left the span to its input");

	a_filter_clear: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_12
		(ce && !gi.dist_active) |=> (dist_filt == '0))
		else $error("disturbance filter not cleared while inactive");

	a_ce_freeze: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_05
		!ce |=> $stable(speed_fb) && $stable(torque_comp) && $stable(func_word_reg))
		else $error("state moved while the clock enable was low");

	a_speed_bypass: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_12
		(step && !gi.speed_active) |=> (speed_fb == $past(meas_speed)))
		else $error("inactive speed observer not bypassed");

	a_comp_bypass: assert property (@(posedge clk_sys) disable iff (rst) // see RULE_12
		(step && !gi.dist_active) |=> (torque_comp == '0))
		else $error("inactive disturbance observer still compensates");
endmodule

// ---- tb/servo_motor_model.sv ----
`timescale 1ns/1ps
module servo_motor_model (
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic               ctrl_tick,
	input  wire logic               locked,
	input  wire logic signed [15:0] torque_cmd,
	input  wire logic signed [15:0] torque_comp,
	output logic signed [15:0]      meas_speed
);
	// Rigid load, speed frozen while the shaft is clamped
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meas_speed <= 16'sh0040;
		end else if (ctrl_tick && !locked) begin
			meas_speed <= meas_speed + ((torque_cmd + torque_comp) >>> 4);
		end
	end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench
	import servo_obs_pkg::*;
;
	logic               clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr;
	logic               ctrl_tick, servo_on, first_gain, locked, gsw, rd_e;
	logic               speed_obs_active, dist_obs_active;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, rd_q;
	logic signed [15:0] meas_speed, torque_cmd, speed_fb, torque_comp, m, e16;
	logic [3:0]         mode, tune;
	logic [2:0]         fw;
	logic [1:0]         ex;
	int                 fail_count, compares, cycles;
	logic [7:0]         offs[6]  = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	logic [31:0]        rvals[6] = '{32'h0, 32'h100, 32'h64, 32'h0, 32'h8, 32'h0};

	servo_speed_disturbance_observer i_servo_speed_disturbance_observer (
		.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ctrl_tick(ctrl_tick),
		.servo_on(servo_on), .first_gain(first_gain), .meas_speed(meas_speed),
		.torque_cmd(torque_cmd), .speed_fb(speed_fb), .torque_comp(torque_comp),
		.speed_obs_active(speed_obs_active), .dist_obs_active(dist_obs_active));

	servo_motor_model i_servo_motor_model (
		.clk_sys(clk_sys), .rst(rst), .ctrl_tick(ctrl_tick), .locked(locked),
		.torque_cmd(torque_cmd), .torque_comp(torque_comp), .meas_speed(meas_speed));

	function automatic logic [1:0] exp_act(input logic [3:0] md, input logic [3:0] at,
		input logic [2:0] f, input logic g, input logic so, input logic fg);
		logic base;
		base = so && (md == MODE_POSITION || md == MODE_VELOCITY) && at == AUTO_TUNE_OFF;
		return {base && !f[0] && f[1] && g && (!f[2] || fg), base && f[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		while (pready !== 1'h1) begin
			@(posedge clk_sys);
		end
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic tick(input logic signed [15:0] tq);
		m = meas_speed;
		torque_cmd <= tq;
		ctrl_tick <= 1'h1;
		@(posedge clk_sys);
		ctrl_tick <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic conclude;
		$display("counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	initial begin
		cycles = 0;
		forever begin
			@(posedge clk_sys);
			cycles++;
			if (cycles == 20000) begin
				fail_count++;
				conclude();
			end
		end
	end

	initial begin
		rst = 1'h1;
		ce = 1'h1;
		{psel, penable, pwrite, ctrl_tick, servo_on, first_gain} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		torque_cmd = 16'sh0000;
		locked = 1'h1;
		fail_count = 0;
		compares = 0;
		void'($urandom(32'h9EF2));
		repeat (20) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
		foreach (offs[i]) begin
			apb(1'h0, offs[i], 32'h0);
			chk("reset_value", rvals[i], rd_q);
		end
		apb(1'h1, 8'h18, 32'hFFFFFFFF);
		chk("unmapped_err", 32'h1, rd_e);
		apb(1'h0, 8'h18, 32'h0);
		chk("unmapped_data", 32'h1, {rd_q[30:0], rd_e});
		apb(1'h1, STATUS_OFS, 32'hFFFFFFFF);
		apb(1'h0, STATUS_OFS, 32'h0);
		chk("status_ro", 32'h0, {rd_q[30:0], rd_e});
		$display("test registers done");

		repeat (60) begin
			mode = ($urandom_range(3) == 0) ? 4'($urandom) : 4'($urandom_range(1));
			tune = ($urandom_range(3) == 0) ? 4'($urandom_range(15, 1)) : 4'h0;
			fw = 3'($urandom);
			gsw = 1'($urandom);
			servo_on <= ($urandom_range(3) != 0);
			first_gain <= 1'($urandom);
			locked <= 1'h0;
			apb(1'h1, MODE_CFG_OFS, {15'h0, gsw, 4'h0, tune, 4'h0, mode});
			apb(1'h1, FUNC_EXP_OFS, {29'h0, fw});
			ex = exp_act(mode, tune, fw, gsw, servo_on, first_gain);
			chk("speed_active", ex[0], speed_obs_active);
			chk("dist_active", ex[1], dist_obs_active);
			apb(1'h0, STATUS_OFS, 32'h0);
			chk("status_bits", ex, rd_q[1:0]);
			tick(16'($urandom_range(255)) - 16'h0080);
			if (!ex[0]) chk("bypass_speed", m, speed_fb);
			chk("zero_gain_comp", 32'h0, torque_comp);
		end
		$display("test gating done");

		locked <= 1'h1;
		servo_on <= 1'h1;
		first_gain <= 1'h1;
		apb(1'h1, MODE_CFG_OFS, 32'h00010000);
		apb(1'h1, FUNC_EXP_OFS, 32'h2);
		apb(1'h1, DIST_GAIN_OFS, 32'h100);
		apb(1'h1, DIST_FILT_OFS, 32'h0);
		repeat (3) tick(16'sh00C8);
		chk("comp_value", 32'hFFFFFF38, torque_comp);
		apb(1'h0, STATUS_OFS, 32'h0);
		chk("dist_estimate", 32'h00C8, rd_q[31:16]);
		apb(1'h1, FUNC_EXP_OFS, 32'h6);
		first_gain <= 1'h0;
		tick(16'sh00C8);
		chk("scope_comp", 32'h0, torque_comp);
		$display("test disturbance done");

		apb(1'h1, FUNC_EXP_OFS, 32'h0);
		apb(1'h1, INERTIA_OFS, 32'h1C);
		tick(16'sh0000);
		apb(1'h1, FUNC_EXP_OFS, 32'h1);
		tick(16'sh0040);
		e16 = m + 16'sh0080;
		chk("model_speed", e16, speed_fb);
		$display("test speed observer done");

		ce <= 1'h0;
		e16 = speed_fb;
		tick(16'sh0040);
		chk("ce_hold_speed", e16, speed_fb);
		chk("ce_pready", 32'h0, pready);
		ce <= 1'h1;
		$display("test clock enable done");
		conclude();
	end
endmodule
